// *** verilog/cpw_defs.svh ***
`ifndef CPW_DEFS_SVH
`define CPW_DEFS_SVH

// Register offsets on the plain register port (byte-wide registers).
`define CPW_OFF_UNIT1_VALUE_LOW      4'h0
`define CPW_OFF_UNIT1_VALUE_HIGH     4'h1
`define CPW_OFF_UNIT1_CONTROL        4'h2
`define CPW_OFF_UNIT2_VALUE_LOW      4'h3
`define CPW_OFF_UNIT2_VALUE_HIGH     4'h4
`define CPW_OFF_UNIT2_CONTROL        4'h5
`define CPW_OFF_TIMER3_CONTROL       4'h6
`define CPW_OFF_PWM_PERIOD           4'h7
`define CPW_OFF_PWM_TIMEBASE         4'h8
`define CPW_OFF_UNIT2_IRQ_FLAGS      4'h9
`define CPW_OFF_UNIT2_IRQ_ENABLES    4'ha
`define CPW_OFF_UNIT2_IRQ_PRIORITIES 4'hb
`define CPW_OFF_UNIT1_IRQ            4'hc
`define CPW_OFF_PWM_CONTROL          4'hd

// Stride between the register groups of unit 1 and unit 2.
`define CPW_UNIT_STRIDE              4'h3

// Field positions.
`define CPW_CTL_MODE_LSB             0
`define CPW_CTL_MODE_MSB             3
`define CPW_CTL_DUTY_LSB_LSB         4
`define CPW_CTL_DUTY_LSB_MSB         5
`define CPW_T3_TIMER_SELECT_LOW      3
`define CPW_T3_TIMER_SELECT_HIGH     6
`define CPW_IRQ_FLAG_BIT             0
`define CPW_IRQ_ENABLE_BIT           1
`define CPW_PWM_RUN_BIT              0

// Reset values.
`define CPW_RST_BYTE                 8'h00
`define CPW_RST_CONTROL              6'h00
`define CPW_RST_PERIOD               8'hff

// Last phase of the increment cycle of the PWM time base.
`define CPW_PHASE_LAST               2'h3

`endif

// *** verilog/cpw_pkg.sv ***
package cpw_pkg;

  // Documented encodings of the four-bit mode select field.
  typedef enum logic [3:0] {
    CPW_MODE_OFF    = 4'h0,
    CPW_MODE_TOGGLE = 4'h2,
    CPW_MODE_SET    = 4'h8,
    CPW_MODE_CLEAR  = 4'h9,
    CPW_MODE_SWINT  = 4'ha,
    CPW_MODE_EVENT  = 4'hb,
    CPW_MODE_PWM    = 4'hc
  } cpw_mode_e;

  typedef logic [7:0] cpw_byte_t;

endpackage

// *** verilog/cpw_compare_pwm_unit.sv ***
// How it works
// - Compare value matched against selected timer.
// - Match drives output high, low, toggle, none.
// - Every compare match sets the match flag.
// - Writing zero to control clears output latch.
// - Mode 1010 only flags; interrupt needs enable.
// - Mode 1011 match clears assigned timer pair.
// - Unit 2 event starts enabled conversion.
// - Unit 1 event never starts conversion.
// - PWM output has 10-bit duty resolution.
// - Period register sets the PWM period.
// - Time base clears after reaching period.
// - Period end sets output unless duty zero.
// - Period end copies buffered duty to active.
// - Duty is low byte over two control bits.
// - Output clears when duty equals extended time base.
// - Duty above period never clears output.
// - Active duty read-only; writes apply at period end.
//
// The implementer's own choices: the placing of the registers and the address-and-strobe port.
`timescale 1ns/1ns
`default_nettype none
`include "cpw_defs.svh"

module cpw_compare_pwm_unit #(
  parameter int unsigned TB_W  = 16,
  parameter int unsigned PWM_W = 8
) (
  input  wire logic             sys_clk_i,
  input  wire logic             rstn_i,
  input  wire logic [3:0]       addr_i,
  input  wire cpw_pkg::cpw_byte_t wdata_i,
  input  wire logic             wr_i,
  input  wire logic             rd_i,
  output var cpw_pkg::cpw_byte_t rdata_o,
  input  wire logic [TB_W-1:0]  timebase_a_i,
  input  wire logic [TB_W-1:0]  timebase_b_i,
  input  wire logic             adc_enabled_i,
  output logic                  timebase_a_clear_o,
  output logic                  timebase_b_clear_o,
  output logic                  adc_start_o,
  output logic                  unit1_out_o,
  output logic                  unit2_out_o,
  output logic                  unit1_irq_o,
  output logic                  unit2_irq_o
);
  import cpw_pkg::*;

  localparam int unsigned NUNITS = 2;

  logic [7:0]       value_low_reg   [NUNITS];
  logic [7:0]       value_high_reg  [NUNITS];
  logic [5:0]       control_reg     [NUNITS];
  logic [1:0]       duty_latch_reg  [NUNITS];
  logic [NUNITS-1:0] out_reg;
  logic [NUNITS-1:0] match_d_reg;
  logic [NUNITS-1:0] flag_reg;
  logic [NUNITS-1:0] irq_en_reg;
  logic [NUNITS-1:0] match_evt;
  logic [NUNITS-1:0] event_evt;
  logic [NUNITS-1:0] sel_b;
  logic [NUNITS-1:0] is_cmp;
  logic [NUNITS-1:0] is_pwm;
  logic [NUNITS-1:0] wr_low;
  logic [NUNITS-1:0] wr_high;
  logic [NUNITS-1:0] wr_ctl;
  logic [NUNITS-1:0] wr_flag;
  logic [NUNITS-1:0] duty_hit;

  logic [7:0]       timer3_ctl_reg;
  logic [7:0]       period_reg;
  logic [PWM_W-1:0] pwm_tb_reg;
  logic [1:0]       phase_reg;
  logic             pwm_run_reg;
  logic             irq_prio_reg;
  logic             a_clear_reg;
  logic             b_clear_reg;
  logic             adc_start_reg;
  cpw_byte_t        rdata_reg;
  logic             incr;
  logic             period_end;
  logic [PWM_W+1:0] pwm_cnt_next;

  // PWM time base: while the run bit is set, a two-bit phase counter steps on every clock and the
  // eight-bit count steps once per four clocks, giving the two extra
  // low bits that widen the duty comparison to ten bits.
  assign incr       = pwm_run_reg && (phase_reg == `CPW_PHASE_LAST);
  assign period_end = incr && (pwm_tb_reg == period_reg[PWM_W-1:0]);
  // The duty compare looks one count ahead, so the registered output falls
  // just as the count reaches the duty value and stays high for duty clocks.
  assign pwm_cnt_next = {pwm_tb_reg, phase_reg} + 1'b1;

  always_ff @(posedge sys_clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      phase_reg <= 2'h0;
    end else if (!pwm_run_reg) begin
      phase_reg <= 2'h0;
    end else begin
      phase_reg <= phase_reg + 2'h1;
    end
  end

  always_ff @(posedge sys_clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      pwm_tb_reg <= '0;
    end else if (period_end) begin
      pwm_tb_reg <= '0;
    end else if (incr) begin
      pwm_tb_reg <= pwm_tb_reg + 1'b1;
    end
  end

  // Shared registers.
  always_ff @(posedge sys_clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      timer3_ctl_reg <= `CPW_RST_BYTE;
      period_reg     <= `CPW_RST_PERIOD;
      pwm_run_reg    <= 1'b0;
      irq_prio_reg   <= 1'b0;
    end else if (wr_i) begin
      case (addr_i)
        `CPW_OFF_TIMER3_CONTROL: begin
          timer3_ctl_reg <= wdata_i;
        end
        `CPW_OFF_PWM_PERIOD: begin
          period_reg <= wdata_i;
        end
        `CPW_OFF_PWM_CONTROL: begin
          pwm_run_reg <= wdata_i[`CPW_PWM_RUN_BIT];
        end
        `CPW_OFF_UNIT2_IRQ_PRIORITIES: begin
          irq_prio_reg <= wdata_i[0];
        end
        default: begin
        end
      endcase
    end
  end

  // Unit 1 follows the high select bit alone; unit 2 moves to the second
  // timer when either select bit is set.
  assign sel_b[0] = timer3_ctl_reg[`CPW_T3_TIMER_SELECT_HIGH];
  assign sel_b[1] = timer3_ctl_reg[`CPW_T3_TIMER_SELECT_HIGH] | timer3_ctl_reg[`CPW_T3_TIMER_SELECT_LOW];

  // Flag write strobes: unit 2 flag sits in its own flags register,
  // unit 1 flag and enable share one register.
  assign wr_flag[0] = wr_i && (addr_i == `CPW_OFF_UNIT1_IRQ);
  assign wr_flag[1] = wr_i && (addr_i == `CPW_OFF_UNIT2_IRQ_FLAGS);

  genvar gi;
  generate
    for (gi = 0; gi < NUNITS; gi++) begin : g_unit
      localparam logic [3:0] BASE = 4'(gi) * `CPW_UNIT_STRIDE;
      logic [3:0]      mode;
      logic [TB_W-1:0] tb_sel;
      logic            match_now;

      assign mode       = control_reg[gi][`CPW_CTL_MODE_MSB:`CPW_CTL_MODE_LSB];
      assign is_pwm[gi] = (mode[3:2] == CPW_MODE_PWM[3:2]);
      assign is_cmp[gi] = (mode == CPW_MODE_TOGGLE) || (mode[3:2] == CPW_MODE_SET[3:2]);
      assign wr_low[gi]  = wr_i && (addr_i == (BASE + `CPW_OFF_UNIT1_VALUE_LOW));
      assign wr_high[gi] = wr_i && (addr_i == (BASE + `CPW_OFF_UNIT1_VALUE_HIGH));
      assign wr_ctl[gi]  = wr_i && (addr_i == (BASE + `CPW_OFF_UNIT1_CONTROL));

      assign tb_sel    = sel_b[gi] ? timebase_b_i : timebase_a_i;
      assign match_now = is_cmp[gi] && ({value_high_reg[gi], value_low_reg[gi]} == tb_sel);
      // A timer may rest on the matching count for many clocks, so only
      // the first clock of a match counts as one event.
      assign match_evt[gi] = match_now && !match_d_reg[gi];
      assign event_evt[gi] = match_evt[gi] && (mode == CPW_MODE_EVENT);
      assign duty_hit[gi]  = ({value_high_reg[gi], duty_latch_reg[gi]} == pwm_cnt_next);

      always_ff @(posedge sys_clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
          match_d_reg[gi] <= 1'b0;
        end else begin
          match_d_reg[gi] <= match_now;
        end
      end

      always_ff @(posedge sys_clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
          value_low_reg[gi] <= `CPW_RST_BYTE;
        end else if (wr_low[gi]) begin
          value_low_reg[gi] <= wdata_i;
        end
      end

      always_ff @(posedge sys_clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
          value_high_reg[gi] <= `CPW_RST_BYTE;
        end else if (is_pwm[gi]) begin
          if (period_end) begin
            value_high_reg[gi] <= value_low_reg[gi];
          end
        end else if (wr_high[gi]) begin
          value_high_reg[gi] <= wdata_i;
        end
      end

      always_ff @(posedge sys_clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
          control_reg[gi] <= `CPW_RST_CONTROL;
        end else if (wr_ctl[gi]) begin
          control_reg[gi] <= wdata_i[`CPW_CTL_DUTY_LSB_MSB:0];
        end
      end

      // Second half of the double buffer for the two low duty bits.
      always_ff @(posedge sys_clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
          duty_latch_reg[gi] <= 2'h0;
        end else if (is_pwm[gi] && period_end) begin
          duty_latch_reg[gi] <= control_reg[gi][`CPW_CTL_DUTY_LSB_MSB:`CPW_CTL_DUTY_LSB_LSB];
        end
      end

      // Output latch. A control write takes priority over a match in the
      // same clock so that software always sees its own write take hold.
      always_ff @(posedge sys_clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
          out_reg[gi] <= 1'b0;
        end else if (wr_ctl[gi]) begin
          if (wdata_i == 8'h00) begin
            out_reg[gi] <= 1'b0;
          end else if (wdata_i[3:0] == CPW_MODE_SET) begin
            out_reg[gi] <= 1'b0;
          end else if (wdata_i[3:0] == CPW_MODE_CLEAR) begin
            out_reg[gi] <= 1'b1;
          end
        end else if (mode == CPW_MODE_OFF) begin
          out_reg[gi] <= 1'b0;
        end else if (is_pwm[gi]) begin
          if (period_end) begin
            out_reg[gi] <= ({value_low_reg[gi],
                             control_reg[gi][`CPW_CTL_DUTY_LSB_MSB:`CPW_CTL_DUTY_LSB_LSB]} != 10'h000);
          end else if (duty_hit[gi]) begin
            out_reg[gi] <= 1'b0;
          end
        end else if (match_evt[gi]) begin
          case (mode)
            CPW_MODE_SET: begin
              out_reg[gi] <= 1'b1;
            end
            CPW_MODE_CLEAR: begin
              out_reg[gi] <= 1'b0;
            end
            CPW_MODE_TOGGLE: begin
              out_reg[gi] <= !out_reg[gi];
            end
            default: begin
              out_reg[gi] <= out_reg[gi];
            end
          endcase
        end
      end

      // The hardware set wins over a software clear in the same clock.
      always_ff @(posedge sys_clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
          flag_reg[gi] <= 1'b0;
        end else if (match_evt[gi]) begin
          flag_reg[gi] <= 1'b1;
        end else if (wr_flag[gi]) begin
          flag_reg[gi] <= wdata_i[`CPW_IRQ_FLAG_BIT];
        end
      end
    end
  endgenerate

  // Interrupt enables.
  always_ff @(posedge sys_clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      irq_en_reg <= '0;
    end else if (wr_flag[0]) begin
      irq_en_reg[0] <= wdata_i[`CPW_IRQ_ENABLE_BIT];
    end else if (wr_i && (addr_i == `CPW_OFF_UNIT2_IRQ_ENABLES)) begin
      irq_en_reg[1] <= wdata_i[0];
    end
  end

  assign unit1_irq_o = flag_reg[0] && irq_en_reg[0];
  assign unit2_irq_o = flag_reg[1] && irq_en_reg[1];
  assign unit1_out_o = out_reg[0];
  assign unit2_out_o = out_reg[1];

  // Special event trigger: clear whichever timer pair each unit uses.
  always_ff @(posedge sys_clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      a_clear_reg <= 1'b0;
      b_clear_reg <= 1'b0;
    end else begin
      a_clear_reg <= (event_evt[0] && !sel_b[0]) || (event_evt[1] && !sel_b[1]);
      b_clear_reg <= (event_evt[0] && sel_b[0]) || (event_evt[1] && sel_b[1]);
    end
  end

  // Only unit 2 may start a conversion, and only into a running converter.
  always_ff @(posedge sys_clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      adc_start_reg <= 1'b0;
    end else begin
      adc_start_reg <= event_evt[1] && adc_enabled_i;
    end
  end

  assign timebase_a_clear_o = a_clear_reg;
  assign timebase_b_clear_o = b_clear_reg;
  assign adc_start_o        = adc_start_reg;

  // Read data stand for exactly one clock after the read strobe.
  always_ff @(posedge sys_clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      rdata_reg <= `CPW_RST_BYTE;
    end else if (!rd_i) begin
      rdata_reg <= `CPW_RST_BYTE;
    end else begin
      case (addr_i)
        `CPW_OFF_UNIT1_VALUE_LOW:      rdata_reg <= value_low_reg[0];
        `CPW_OFF_UNIT1_VALUE_HIGH:     rdata_reg <= value_high_reg[0];
        `CPW_OFF_UNIT1_CONTROL:        rdata_reg <= {2'h0, control_reg[0]};
        `CPW_OFF_UNIT2_VALUE_LOW:      rdata_reg <= value_low_reg[1];
        `CPW_OFF_UNIT2_VALUE_HIGH:     rdata_reg <= value_high_reg[1];
        `CPW_OFF_UNIT2_CONTROL:        rdata_reg <= {2'h0, control_reg[1]};
        `CPW_OFF_TIMER3_CONTROL:       rdata_reg <= timer3_ctl_reg;
        `CPW_OFF_PWM_PERIOD:           rdata_reg <= period_reg;
        `CPW_OFF_PWM_TIMEBASE:         rdata_reg <= 8'(pwm_tb_reg);
        `CPW_OFF_UNIT2_IRQ_FLAGS:      rdata_reg <= {7'h00, flag_reg[1]};
        `CPW_OFF_UNIT2_IRQ_ENABLES:    rdata_reg <= {7'h00, irq_en_reg[1]};
        `CPW_OFF_UNIT2_IRQ_PRIORITIES: rdata_reg <= {7'h00, irq_prio_reg};
        `CPW_OFF_UNIT1_IRQ:            rdata_reg <= {6'h00, irq_en_reg[0], flag_reg[0]};
        `CPW_OFF_PWM_CONTROL:          rdata_reg <= {7'h00, pwm_run_reg};
        default:                       rdata_reg <= `CPW_RST_BYTE;
      endcase
    end
  end

  assign rdata_o = rdata_reg;

endmodule

`default_nettype wire

// *** bench/cpw_timer_model.sv ***
`timescale 1ns/1ns
`default_nettype none

module cpw_timer_model (
  input  wire logic        sys_clk_i,
  input  wire logic        rstn_i,
  input  wire logic        clear_a_i,
  input  wire logic        clear_b_i,
  output logic      [15:0] tb_a_o,
  output logic      [15:0] tb_b_o,
  input  wire logic        unit2_out_i,
  output logic             pin2_o
);
  // The direction bit stays cleared so the unit, not the port latch, drives
  // the pin; a set bit would let the pull-up show through instead.
  logic pin_direction_bit;
  assign pin_direction_bit = 1'b0;
  assign pin2_o = pin_direction_bit ? 1'b1 : unit2_out_i;
  // Both timers step on the core clock, never asynchronously.
  // The second one steps by three so a wrong timer choice misses the match.
  always_ff @(posedge sys_clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      tb_a_o <= 16'h0000;
      tb_b_o <= 16'h0100;
    end else begin
      tb_a_o <= clear_a_i ? 16'h0000 : tb_a_o + 16'h0001;
      tb_b_o <= clear_b_i ? 16'h0000 : tb_b_o + 16'h0003;
    end
  end
endmodule

`default_nettype wire

// *** bench/cpw_checker.sv ***
`timescale 1ns/1ns
`default_nettype none
`include "cpw_defs.svh"

module cpw_checker (
  input wire logic                sys_clk_i,
  input wire logic                rstn_i,
  input wire logic [3:0]          addr_i,
  input wire cpw_pkg::cpw_byte_t  wdata_i,
  input wire logic                wr_i,
  input wire logic                adc_enabled_i,
  input wire logic                timebase_a_clear_o,
  input wire logic                timebase_b_clear_o,
  input wire logic                adc_start_o,
  input wire logic                unit1_out_o,
  input wire logic                unit2_out_o,
  input wire logic                unit2_irq_o
);
  import cpw_pkg::*;
  logic c1_w;
  logic c2_w;
  assign c1_w = wr_i && addr_i == `CPW_OFF_UNIT1_CONTROL;
  assign c2_w = wr_i && addr_i == `CPW_OFF_UNIT2_CONTROL;
  default clocking cb @(posedge sys_clk_i);
  endclocking
  default disable iff (!rstn_i);

  property p_zero_u1;
    c1_w && wdata_i == 8'h00 |=> !unit1_out_o;
  endproperty
  a_zero_u1: assert property (p_zero_u1) else $error("unit1 output not low");
  property p_zero_u2;
    c2_w && wdata_i == 8'h00 |=> !unit2_out_o;
  endproperty
  a_zero_u2: assert property (p_zero_u2) else $error("unit2 output not low");
  property p_set_init;
    c2_w && wdata_i[3:0] == CPW_MODE_SET |=> !unit2_out_o;
  endproperty
  a_set_init: assert property (p_set_init) else $error("set mode start level");
  property p_clr_init;
    c1_w && wdata_i[3:0] == CPW_MODE_CLEAR |=> unit1_out_o;
  endproperty
  a_clr_init: assert property (p_clr_init) else $error("clear mode start level");
  property p_irq_off;
    wr_i && addr_i == `CPW_OFF_UNIT2_IRQ_ENABLES && !wdata_i[0] |=> !unit2_irq_o;
  endproperty
  a_irq_off: assert property (p_irq_off) else $error("irq without enable");
  property p_adc_clr;
    adc_start_o |-> timebase_a_clear_o || timebase_b_clear_o;
  endproperty
  a_adc_clr: assert property (p_adc_clr) else $error("conversion without trigger");
  property p_adc_en;
    adc_start_o |-> $past(adc_enabled_i) || $past(adc_enabled_i, 2);
  endproperty
  a_adc_en: assert property (p_adc_en) else $error("conversion while disabled");
  property p_pulse_a;
    timebase_a_clear_o |=> !timebase_a_clear_o;
  endproperty
  a_pulse_a: assert property (p_pulse_a) else $error("long clear pulse a");
  property p_pulse_b;
    timebase_b_clear_o |=> !timebase_b_clear_o;
  endproperty
  a_pulse_b: assert property (p_pulse_b) else $error("long clear pulse b");
endmodule

bind cpw_compare_pwm_unit cpw_checker i_cpw_checker (.sys_clk_i, .rstn_i, .addr_i, .wdata_i, .wr_i,
  .adc_enabled_i, .timebase_a_clear_o, .timebase_b_clear_o, .adc_start_o, .unit1_out_o, .unit2_out_o,
  .unit2_irq_o);

`default_nettype wire

// *** bench/tb_top.sv ***
`timescale 1ns/1ns
`default_nettype none
`include "cpw_defs.svh"

module tb_top;
  import cpw_pkg::*;
  logic        sys_clk_i = 1'b0;
  logic        rstn_i = 1'b0;
  logic [3:0]  addr_i = 4'h0;
  cpw_byte_t   wdata_i = 8'h00;
  logic        wr_i = 1'b0;
  logic        rd_i = 1'b0;
  logic        adc_en = 1'b0;
  cpw_byte_t   rdata_o;
  cpw_byte_t   d;
  logic [15:0] tb_a;
  logic [15:0] tb_b;
  logic        clr_a, clr_b, adc_st, out1, out2, irq1, irq2, pin2;
  int          mismatches = 0;
  int          n_checks = 0;
  int          seed = 48860;
  int          n_ca = 0;
  int          n_cb = 0;
  int          n_ad = 0;
  int          p, dv;
  int          pp[3] = '{0, 2, 3};
  int          dd[3] = '{0, 1, 12};
  logic [3:0]  ra[5] = '{4'h0, 4'h1, 4'h3, 4'h4, 4'h7};

  always #5 sys_clk_i = ~sys_clk_i;

  cpw_compare_pwm_unit i_cpw_compare_pwm_unit (.sys_clk_i, .rstn_i, .addr_i, .wdata_i, .wr_i, .rd_i,
    .rdata_o, .timebase_a_i(tb_a), .timebase_b_i(tb_b), .adc_enabled_i(adc_en),
    .timebase_a_clear_o(clr_a), .timebase_b_clear_o(clr_b), .adc_start_o(adc_st),
    .unit1_out_o(out1), .unit2_out_o(out2), .unit1_irq_o(irq1), .unit2_irq_o(irq2));
  cpw_timer_model i_cpw_timer_model (.sys_clk_i, .rstn_i, .clear_a_i(clr_a), .clear_b_i(clr_b),
    .tb_a_o(tb_a), .tb_b_o(tb_b), .unit2_out_i(out2), .pin2_o(pin2));

  always @(posedge sys_clk_i) begin
    n_ca <= n_ca + int'(clr_a);
    n_cb <= n_cb + int'(clr_b);
    n_ad <= n_ad + int'(adc_st);
  end

  task automatic note(input bit ok, input string what);
    n_checks++;
    if (!ok) begin
      mismatches++;
      $display("[ERR] %0t %s mismatch", $time, what);
    end
  endtask
  task automatic chk_reg(input cpw_byte_t g, input cpw_byte_t e);
    note(g === e, "register");
  endtask
  task automatic chk_bit(input logic g, input logic e);
    note(g === e, "signal");
  endtask
  task automatic chk_cnt(input int g, input int e);
    note(g == e, "count");
  endtask

  // Every access ends on a falling edge so the caller sees settled outputs.
  task automatic wr(input logic [3:0] a, input cpw_byte_t v);
    @(posedge sys_clk_i);
    addr_i <= a;
    wdata_i <= v;
    wr_i <= 1'b1;
    @(posedge sys_clk_i);
    wr_i <= 1'b0;
    @(negedge sys_clk_i);
  endtask
  task automatic rd(input logic [3:0] a, output cpw_byte_t v);
    @(posedge sys_clk_i);
    addr_i <= a;
    rd_i <= 1'b1;
    @(posedge sys_clk_i);
    rd_i <= 1'b0;
    @(negedge sys_clk_i);
    v = rdata_o;
  endtask

  function automatic logic f_out(input cpw_mode_e m, input logic prev);
    case (m)
      CPW_MODE_SET: return 1'b1;
      CPW_MODE_CLEAR: return 1'b0;
      CPW_MODE_TOGGLE: return !prev;
      default: return prev;
    endcase
  endfunction
  function automatic int f_high(input int dv, input int p);
    return dv >= 4 * (p + 1) ? 4 * (p + 1) : dv;
  endfunction

  task automatic cmp_run(input int u, input logic ae);
    cpw_mode_e   m[5] = '{CPW_MODE_SET, CPW_MODE_CLEAR, CPW_MODE_TOGGLE, CPW_MODE_SWINT, CPW_MODE_EVENT};
    logic [3:0]  b;
    cpw_byte_t   t3;
    cpw_byte_t   f;
    logic [15:0] v;
    logic        o, en, ub, ev;
    int          ca, cb, cd;
    b = (u == 1) ? 4'h0 : 4'h3;
    o = 1'b0;
    @(posedge sys_clk_i);
    adc_en <= ae;
    foreach (m[i]) begin
      t3 = 8'($random(seed));
      en = 1'($random(seed));
      ub = (u == 1) ? t3[6] : (t3[6] | t3[3]);
      ev = m[i] == CPW_MODE_EVENT;
      wr(`CPW_OFF_TIMER3_CONTROL, t3);
      wr(b + 4'h2, {4'h0, m[i]});
      if (m[i] == CPW_MODE_SET || m[i] == CPW_MODE_CLEAR) o = m[i][0];
      chk_bit(u == 1 ? out1 : out2, o);
      if (u == 1) begin
        wr(`CPW_OFF_UNIT1_IRQ, {6'h00, en, 1'b0});
      end else begin
        wr(`CPW_OFF_UNIT2_IRQ_FLAGS, 8'h00);
        wr(`CPW_OFF_UNIT2_IRQ_ENABLES, {7'h00, en});
      end
      v = (ub ? tb_b : tb_a) + 16'h003c;
      ca = n_ca;
      cb = n_cb;
      cd = n_ad;
      wr(b, v[7:0]);
      wr(b + 4'h1, v[15:8]);
      repeat (60) @(negedge sys_clk_i);
      o = f_out(m[i], o);
      chk_bit(u == 1 ? out1 : out2, o);
      rd(u == 1 ? `CPW_OFF_UNIT1_IRQ : `CPW_OFF_UNIT2_IRQ_FLAGS, f);
      chk_bit(f[0], 1'b1);
      chk_bit(u == 1 ? irq1 : irq2, en);
      chk_cnt(n_ca - ca, int'(ev & !ub));
      chk_cnt(n_cb - cb, int'(ev & ub));
      chk_cnt(n_ad - cd, int'(ev & u == 2 & ae));
    end
    wr(b + 4'h2, 8'h00);
    chk_bit(u == 1 ? out1 : out2, 1'b0);
  endtask

  // A shorter period may start with the time base above it, so allow one full wrap.
  task automatic pwm_run(input int p, input int dv);
    int hi;
    wr(`CPW_OFF_PWM_PERIOD, p[7:0]);
    wr(`CPW_OFF_UNIT2_VALUE_LOW, dv[9:2]);
    wr(`CPW_OFF_UNIT2_CONTROL, {2'b00, dv[1:0], CPW_MODE_PWM});
    repeat (1040 + 8 * (p + 1)) @(negedge sys_clk_i);
    hi = 0;
    repeat (4 * (p + 1)) begin
      @(negedge sys_clk_i);
      hi += int'(pin2);
    end
    chk_cnt(hi, f_high(dv, p));
  endtask

  task automatic complete_run;
    $display("checks %0d mismatches %0d", n_checks, mismatches);
    if (mismatches == 0 && n_checks > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask

  initial begin
    #400000;
    mismatches++;
    complete_run;
  end

  initial begin
    repeat (4) @(posedge sys_clk_i);
    rstn_i <= 1'b1;
    for (int a = 0; a < 16; a++) begin
      rd(a[3:0], d);
      chk_reg(d, a == 7 ? `CPW_RST_PERIOD : 8'h00);
    end
    foreach (ra[i]) begin
      dv = $random(seed);
      wr(ra[i], dv[7:0]);
      rd(ra[i], d);
      chk_reg(d, dv[7:0]);
    end
    wr(`CPW_OFF_UNIT1_CONTROL, {2'b00, dv[5:4], 4'h0});
    rd(`CPW_OFF_UNIT1_CONTROL, d);
    chk_reg(d, {2'b00, dv[5:4], 4'h0});
    wr(`CPW_OFF_PWM_TIMEBASE, 8'hff);
    wr(4'he, 8'hff);
    rd(`CPW_OFF_PWM_TIMEBASE, d);
    chk_reg(d, 8'h00);
    rd(4'he, d);
    chk_reg(d, 8'h00);
    $display("registers done");
    cmp_run(1, 1'b1);
    cmp_run(2, 1'b0);
    cmp_run(2, 1'b1);
    $display("compare done");
    wr(`CPW_OFF_PWM_CONTROL, 8'h01);
    for (int i = 0; i < 6; i++) begin
      p = i < 3 ? pp[i] : 1 + ($random(seed) & 7);
      dv = i < 3 ? dd[i] : ($random(seed) & 1023) % (4 * p + 8);
      pwm_run(p, dv);
    end
    wr(`CPW_OFF_UNIT2_VALUE_HIGH, ~dv[9:2]);
    rd(`CPW_OFF_UNIT2_VALUE_HIGH, d);
    chk_reg(d, dv[9:2]);
    wr(`CPW_OFF_UNIT2_VALUE_LOW, 8'h5a);
    repeat (8 * (p + 1) + 8) @(negedge sys_clk_i);
    rd(`CPW_OFF_UNIT2_VALUE_HIGH, d);
    chk_reg(d, 8'h5a);
    repeat (5) begin
      rd(`CPW_OFF_PWM_TIMEBASE, d);
      chk_bit(d <= p, 1'b1);
    end
    wr(`CPW_OFF_UNIT2_CONTROL, 8'h00);
    chk_bit(out2, 1'b0);
    $display("pwm done");
    complete_run;
  end
endmodule

`default_nettype wire
